// File: src/lpt_timing_gen.sv
// Purpose: Panel frame, line, shift, enable and bias timing generator
// Assumes: clk is twice the pixel rate; pixel_in is on clk
// Notes:   Registers over Avalon-MM with one wait state
//
// Operation
// (R1) Vertical display equals active field plus one
// (R2) Vertical total equals total field plus one
// (R3) Horizontal total is field plus one, times eight
// (R4) Horizontal display is field plus one, times eight
// (R5) Software keeps TFT display width eight-pixel multiples
// (R6) Line pulse starts at field plus one
// (R7) Line pulse width is field plus one
// (R8) Horizontal display starts at field plus five
// (R9) Frame pulse starts at field, no offset
// (R10) Frame pulse width is field plus one lines
// (R11) Vertical display starts at field directly
// (R12) Panel type 01 selects TFT interface
// (R13) Line polarity bit zero means active low
// (R14) Frame polarity bit zero means active low
// (R15) TFT frame pulse leads line pulse by start
// (R16) TFT enable follows line by start difference
// (R17) TFT line repeats per total; enable ends early
// (R18) TFT shift clock one pixel, data mid-cycle
// (R19) TFT second blank part is start difference
// (R20) Format-two shift period two pixels
// (R21) Sixteen-bit shift period five, phases two+
// (R22) Passive frame precedes line; bias toggles early
// (R23) Passive last shift edge before line rise
// (R24) Passive first shift edge after line fall
// (R25) Pixel and line counters wrap at totals
//
// Design decision made here: the Avalon-MM slave port.
`timescale 1ns/1ns
`default_nettype none
module lpt_timing_gen (
	input  wire logic                 clk,
	input  wire logic                 rst,
	input  wire lpt_pkg::lpt_avs_req_t avs_req,
	output var  logic [31:0]          avs_readdata,
	output var  logic                 avs_waitrequest,
	input  wire logic [15:0]          pixel_in,
	output var  logic                 pixel_take,
	output var  lpt_pkg::lpt_panel_t  panel
);
	import lpt_pkg::*;

	// Full modulo; software may load starts far past the total
	function automatic logic [10:0] wrapm(input logic [10:0] a, input logic [10:0] tot);
		return 11'(a % tot);
	endfunction : wrapm

	// Distance from start to pos, modulo tot
	function automatic logic [10:0] offs(input logic [10:0] pos, input logic [10:0] start,
			input logic [10:0] tot);
		logic [10:0] s;
		logic [10:0] p;
		s = wrapm(start, tot);
		p = wrapm(pos, tot);
		return (p >= s) ? 11'(p - s) : 11'(p + tot - s);
	endfunction : offs

	function automatic logic mapped(input logic [5:0] i);
		return (i == IDX_PANEL) || (i == IDX_HTOT) || (i == IDX_HACT)
			|| (i >= IDX_HORIZ_ACTIVE_START_L && i <= IDX_VTOT_H)
			|| (i >= IDX_VACT_L && i <= IDX_HPW)
			|| (i == IDX_HPS_L) || (i == IDX_HPS_H) || (i == IDX_VPW)
			|| (i == IDX_VPS_L) || (i == IDX_VPS_H);
	endfunction : mapped

	logic [7:0]     cfg [NUM_IDX];
	lpt_bus_state_t state_reg;
	logic           wait_reg;
	logic [31:0]    rdata_reg;
	logic           ph_reg;
	logic [10:0]    hcnt_reg;
	logic [10:0]    hcnt_next;
	logic [10:0]    vcnt_reg;
	logic [10:0]    vcnt_next;
	lpt_panel_t     pan_reg;
	lpt_panel_t     pan_next;
	logic           take_reg;

	// Bus decode
	wire       req     = avs_req.read || avs_req.write;
	wire [5:0] idx     = avs_req.address[7:2];
	wire       commit  = (state_reg == BUS_ACK) && avs_req.write && mapped(idx);

	// Timing fields
	wire [10:0] ht   = 11'((11'(cfg[IDX_HTOT][6:0]) + H_ONE) << H_SHIFT); // (R3)
	wire [10:0] horiz_active_width  = 11'((11'(cfg[IDX_HACT][6:0]) + H_ONE) << H_SHIFT); // (R4)
	wire [10:0] line_pulse_start  = 11'(11'({cfg[IDX_HPS_H][1:0], cfg[IDX_HPS_L]}) + H_ONE); // (R6)
	wire [10:0] line_pulse_width  = 11'(11'(cfg[IDX_HPW][6:0]) + H_ONE); // (R7)
	wire [10:0] horiz_active_start = 11'(11'({cfg[IDX_HORIZ_ACTIVE_START_H][1:0], cfg[IDX_HORIZ_ACTIVE_START_L]}) + HORIZ_ACTIVE_START_OFS); // (R8)
	wire [10:0] vt   = 11'(11'({cfg[IDX_VTOT_H][1:0], cfg[IDX_VTOT_L]}) + H_ONE); // (R2)
	wire [10:0] vert_active_lines  = 11'(11'({cfg[IDX_VACT_H][1:0], cfg[IDX_VACT_L]}) + H_ONE); // (R1)
	wire [10:0] frame_pulse_start  = 11'({cfg[IDX_VPS_H][1:0], cfg[IDX_VPS_L]}); // (R9)
	wire [10:0] frame_pulse_width  = 11'(11'(cfg[IDX_VPW][2:0]) + H_ONE); // (R10)
	wire [10:0] vert_active_start = 11'({cfg[IDX_VERT_ACTIVE_START_H][1:0], cfg[IDX_VERT_ACTIVE_START_L]}); // (R11)
	wire        is_tft   = cfg[IDX_PANEL][1:0] == PT_TFT; // (R12)
	wire        wide     = cfg[IDX_PANEL][PT_WIDE_BIT];
	wire        line_pol = cfg[IDX_VPW][POL_BIT]; // (R13)
	wire        frm_pol  = cfg[IDX_HPW][POL_BIT]; // (R14)

	// Second blank part, shown in status
	wire [10:0] vblank2 = offs(vert_active_start, frame_pulse_start, vt); // (R19)

	// Counters; tick ends a pixel
	wire        tick  = ph_reg;
	wire        hlast = hcnt_reg >= 11'(ht - H_ONE);
	wire        vlast = vcnt_reg >= 11'(vt - H_ONE);
	assign hcnt_next = !tick ? hcnt_reg : (hlast ? 11'h000 : 11'(hcnt_reg + H_ONE)); // (R25)
	assign vcnt_next = !(tick && hlast) ? vcnt_reg
		: (vlast ? 11'h000 : 11'(vcnt_reg + H_ONE)); // (R25)

	// Windows of the current pixel
	wire [10:0] hoff     = offs(hcnt_reg, horiz_active_start, ht);
	wire [10:0] p5       = 11'(hoff % SC16_PER);
	wire        hde      = hoff < horiz_active_width; // (R4)
	wire        vde      = offs(vcnt_reg, vert_active_start, vt) < vert_active_lines; // (R1)
	wire        de       = hde && vde; // (R17)
	wire        line_act = offs(hcnt_reg, line_pulse_start, ht) < line_pulse_width; // (R6)
	wire        frm_tft  = offs(vcnt_reg, frame_pulse_start, vt) < frame_pulse_width; // (R15)
	wire        frm_pas  = vcnt_reg == wrapm(frame_pulse_start, vt); // (R22)
	wire        frm_act  = is_tft ? frm_tft : frm_pas;
	// Passive shift phases from display start
	wire        sc_f2    = de && !hoff[0]; // (R20)
	wire        sc_16    = de && (p5 < SC16_HIGH); // (R21)
	wire        sc_pas   = wide ? sc_16 : sc_f2; // (R24)
	wire        load_f2  = de && !hoff[0];
	wire        load_16  = de && (p5 == SC16_HIGH); // (R21)
	wire        load     = is_tft ? de : (wide ? load_16 : load_f2); // (R23)
	wire        bias_hit = !is_tft && (hcnt_reg == BIAS_HCNT); // (R22)
	wire        upd      = !ph_reg;

	// Outputs other than the TFT shift clock refresh half a pixel after the counters move
	always_comb begin
		pan_next = pan_reg;
		pan_next.shift_clock = is_tft ? !ph_reg : pan_reg.shift_clock; // (R18)
		if (upd) begin
			pan_next.line_pulse  = line_pol ? line_act : !line_act; // (R13)
			pan_next.frame_pulse = frm_pol ? frm_act : !frm_act; // (R14)
			pan_next.display_enable_strobe = is_tft && de; // (R16)
			if (!is_tft) begin
				pan_next.shift_clock = sc_pas; // (R24)
			end
			if (bias_hit) begin
				pan_next.ac_bias_toggle = !pan_reg.ac_bias_toggle; // (R22)
			end
			if (load) begin
				pan_next.panel_data_bus = wide || is_tft ? pixel_in
					: {8'h00, pixel_in[7:0]}; // (R20)
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			ph_reg   <= 1'b0;
			hcnt_reg <= 11'h000;
			vcnt_reg <= 11'h000;
			pan_reg  <= '0;
			take_reg <= 1'b0;
		end else begin
			ph_reg   <= !ph_reg;
			hcnt_reg <= hcnt_next;
			vcnt_reg <= vcnt_next;
			pan_reg  <= pan_next;
			take_reg <= upd && load;
		end
	end

	// Register file; unmapped bytes never change
	always_ff @(posedge clk) begin
		if (rst) begin
			for (int i = 0; i < NUM_IDX; i++) begin
				cfg[i] <= CFG_RESET;
			end
		end else if (commit) begin
			cfg[idx] <= avs_req.writedata[7:0];
		end
	end

	// Read mux; line and second-blank status bytes read live, other unmapped reads return zero
	wire [7:0] rd_byte = (idx == IDX_ST_LINE) ? vcnt_reg[7:0]
		: (idx == IDX_ST_VB2) ? vblank2[7:0]
		: (idx < 6'(NUM_IDX) && mapped(idx)) ? cfg[idx] : 8'h00;

	// One wait state: answer on the second edge of every request
	always_ff @(posedge clk) begin
		if (rst) begin
			state_reg <= BUS_IDLE;
			wait_reg  <= 1'b1;
			rdata_reg <= 32'h0000_0000;
		end else begin
			case (state_reg)
				BUS_IDLE: begin
					if (req) begin
						state_reg <= BUS_ACK;
						wait_reg  <= 1'b0;
						rdata_reg <= {24'h000000, rd_byte};
					end
				end
				BUS_ACK: begin
					state_reg <= BUS_IDLE;
					wait_reg  <= 1'b1;
				end
				default: begin
					state_reg <= BUS_IDLE;
					wait_reg  <= 1'b1;
				end
			endcase
		end
	end

	assign avs_readdata    = rdata_reg;
	assign avs_waitrequest = wait_reg;
	assign pixel_take      = take_reg;
	assign panel           = pan_reg;

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	a_bus_one_wait: assert property (
		(state_reg == BUS_IDLE && req) |=> !avs_waitrequest ##1 avs_waitrequest)
		else $error("bus answer not after one wait state");
	a_htot_wrap: assert property ( // (R3)
		(tick && hcnt_reg == 11'(ht - H_ONE)) |=> hcnt_reg == 11'h000)
		else $error("pixel counter did not wrap at total");
	a_vtot_wrap: assert property ( // (R2)
		(tick && hlast && vcnt_reg == 11'(vt - H_ONE)) |=> vcnt_reg == 11'h000)
		else $error("line counter did not wrap at total");
	a_line_start: assert property ( // (R6)
		(upd && hcnt_reg == wrapm(line_pulse_start, ht) && $stable(line_pulse_start) && !line_pol)
		|=> !panel.line_pulse)
		else $error("line pulse not active at its start");
	a_line_polarity: assert property ( // (R13)
		(upd && !line_act) |=> panel.line_pulse == !$past(line_pol))
		else $error("idle line pulse level wrong");
	a_tft_shift: assert property ( // (R18)
		(is_tft && ph_reg ##1 is_tft) |-> !panel.shift_clock ##1 panel.shift_clock)
		else $error("tft shift clock not one pixel period");
	a_tft_enable: assert property ( // (R16)
		(upd && is_tft && de) |=> panel.display_enable_strobe ##1 panel.display_enable_strobe)
		else $error("tft enable missing in display window");
	a_frame_edge: assert property ( // (R15)
		($changed(frm_tft) && $stable(frame_pulse_start) && $stable(frame_pulse_width) && $stable(vt)) |-> hcnt_reg == 11'h000)
		else $error("frame pulse edge away from line start");
	a_vblank2_range: assert property ( // (R19)
		vblank2 < vt)
		else $error("second blank part out of range");
	a_de_start_max: assert property ( // (R16)
		(is_tft && $rose(hde) && $stable(horiz_active_start)) |-> offs(horiz_active_start, line_pulse_start, ht) <= DE_MAX)
		else $error("enable starts too late after line pulse");

	// Line and frame levels
	a_line_active: assert property ( // (R7)
		(upd && line_act)
		|=> panel.line_pulse == $past(line_pol))
		else $error("line pulse not active inside its width");
	a_line_hold: assert property ( // (R17)
		!upd
		|=> $stable(panel.line_pulse))
		else $error("line pulse moved inside a pixel");
	a_frame_active: assert property ( // (R14)
		(upd && frm_act)
		|=> panel.frame_pulse == $past(frm_pol))
		else $error("frame pulse not active in its window");
	a_frame_idle: assert property ( // (R14)
		(upd && !frm_act)
		|=> panel.frame_pulse == !$past(frm_pol))
		else $error("frame pulse active outside its window");
	a_frame_hold: assert property ( // (R15)
		!upd
		|=> $stable(panel.frame_pulse))
		else $error("frame pulse moved inside a pixel");
	a_tft_frame: assert property ( // (R10)
		(upd && is_tft && offs(vcnt_reg, frame_pulse_start, vt) < frame_pulse_width)
		|=> panel.frame_pulse == $past(frm_pol))
		else $error("tft frame pulse shorter than its width");
	a_pas_frame: assert property ( // (R22)
		(upd && !is_tft && vcnt_reg == wrapm(frame_pulse_start, vt))
		|=> panel.frame_pulse == $past(frm_pol))
		else $error("passive frame pulse missing on start line");

	// Enable and data
	a_enable_off: assert property ( // (R17)
		(upd && !(is_tft && de))
		|=> !panel.display_enable_strobe)
		else $error("enable active outside display");
	a_enable_hold: assert property ( // (R16)
		!upd
		|=> $stable(panel.display_enable_strobe))
		else $error("enable moved inside a pixel");
	a_disp_start: assert property ( // (R8)
		(upd && is_tft && vde && hcnt_reg == wrapm(horiz_active_start, ht))
		|=> panel.display_enable_strobe)
		else $error("enable missing at display start pixel");
	a_vdisp_start: assert property ( // (R11)
		(upd && is_tft && hde && vcnt_reg == wrapm(vert_active_start, vt))
		|=> panel.display_enable_strobe)
		else $error("enable missing on display start line");
	a_tft_take: assert property ( // (R16)
		(upd && is_tft && de)
		|=> pixel_take)
		else $error("no pixel taken in tft display");
	a_take_single: assert property ( // (R18)
		pixel_take
		|=> !pixel_take)
		else $error("pixel take longer than one cycle");
	a_pas_take: assert property ( // (R23)
		(upd && !is_tft && !load)
		|=> !pixel_take)
		else $error("passive pixel taken off its load slot");
	a_tft_data: assert property ( // (R18)
		(upd && is_tft && de)
		|=> panel.panel_data_bus == $past(pixel_in))
		else $error("tft data not the taken pixel");
	a_data_hold: assert property ( // (R18)
		!upd
		|=> $stable(panel.panel_data_bus))
		else $error("panel data moved inside a pixel");

	// Passive shift clock
	a_f2_high: assert property ( // (R20)
		(upd && !is_tft && !wide && de && !hoff[0])
		|=> panel.shift_clock && panel.panel_data_bus[15:8] == 8'h00)
		else $error("format two shift high phase wrong");
	a_f2_low: assert property ( // (R20)
		(upd && !is_tft && !wide && de && hoff[0])
		|=> !panel.shift_clock)
		else $error("format two shift low phase wrong");
	a_w16_high: assert property ( // (R21)
		(upd && !is_tft && wide && de && p5 < SC16_HIGH)
		|=> panel.shift_clock)
		else $error("wide shift high phase wrong");
	a_w16_low: assert property ( // (R21)
		(upd && !is_tft && wide && de && p5 >= SC16_HIGH)
		|=> !panel.shift_clock)
		else $error("wide shift low phase wrong");
	a_w16_data: assert property ( // (R21)
		(upd && !is_tft && wide && de && p5 == SC16_HIGH)
		|=> panel.panel_data_bus == $past(pixel_in))
		else $error("wide data not loaded at shift fall");
	a_pas_idle_shift: assert property ( // (R23)
		(upd && !is_tft && !de)
		|=> !panel.shift_clock)
		else $error("passive shift runs outside display");
	a_pas_shift_hold: assert property ( // (R24)
		(!upd && !is_tft)
		|=> $stable(panel.shift_clock))
		else $error("passive shift moved inside a pixel");

	// Bias toggle
	a_bias_toggle: assert property ( // (R22)
		(upd && bias_hit)
		|=> panel.ac_bias_toggle != $past(panel.ac_bias_toggle))
		else $error("bias did not toggle on its pixel");
	a_bias_hold: assert property ( // (R22)
		!(upd && bias_hit)
		|=> $stable(panel.ac_bias_toggle))
		else $error("bias toggled off its pixel");

	// Counters and bus
	a_phase_flip: assert property ( // (R18)
		1'b1
		|=> ph_reg != $past(ph_reg))
		else $error("pixel phase did not alternate");
	a_hcnt_hold: assert property ( // (R25)
		!tick
		|=> $stable(hcnt_reg))
		else $error("pixel counter moved off its tick");
	a_vcnt_hold: assert property ( // (R25)
		!(tick && hlast)
		|=> $stable(vcnt_reg))
		else $error("line counter moved off line end");
	a_upper_zero: assert property (
		!avs_waitrequest
		|-> avs_readdata[31:8] == 24'h000000)
		else $error("read data upper bits not zero");
	a_unmapped_read: assert property (
		(state_reg == BUS_IDLE && avs_req.read && !mapped(idx) && idx != IDX_ST_LINE && idx != IDX_ST_VB2)
		|=> avs_readdata == 32'h0000_0000)
		else $error("unmapped read not zero");
	a_reset_wait: assert property (
		disable iff (1'b0) rst
		|=> avs_waitrequest && !pixel_take)
		else $error("bus or take active after reset");
endmodule : lpt_timing_gen
`default_nettype wire

// File: src/lpt_pkg.sv
// Purpose: Shared constants and types of the panel timing generator
// Assumes: One pixel period spans two system clocks
// Notes:   Register indices; byte address is four times the index
package lpt_pkg;
	// Register indices
	localparam logic [5:0] IDX_PANEL  = 6'h10;
	localparam logic [5:0] IDX_HTOT   = 6'h12;
	localparam logic [5:0] IDX_HACT   = 6'h14;
	localparam logic [5:0] IDX_HORIZ_ACTIVE_START_L = 6'h16;
	localparam logic [5:0] IDX_HORIZ_ACTIVE_START_H = 6'h17;
	localparam logic [5:0] IDX_VTOT_L = 6'h18;
	localparam logic [5:0] IDX_VTOT_H = 6'h19;
	localparam logic [5:0] IDX_VACT_L = 6'h1c;
	localparam logic [5:0] IDX_VACT_H = 6'h1d;
	localparam logic [5:0] IDX_VERT_ACTIVE_START_L = 6'h1e;
	localparam logic [5:0] IDX_VERT_ACTIVE_START_H = 6'h1f;
	localparam logic [5:0] IDX_HPW    = 6'h20;
	localparam logic [5:0] IDX_HPS_L  = 6'h22;
	localparam logic [5:0] IDX_HPS_H  = 6'h23;
	localparam logic [5:0] IDX_VPW    = 6'h24;
	localparam logic [5:0] IDX_VPS_L  = 6'h26;
	localparam logic [5:0] IDX_VPS_H  = 6'h27;
	localparam logic [5:0] IDX_ST_LINE = 6'h28;
	localparam logic [5:0] IDX_ST_VB2  = 6'h29;
	localparam int unsigned NUM_IDX    = 42;
	// Fields and reset values
	localparam logic [7:0]  CFG_RESET   = 8'h00;
	localparam logic [1:0]  PT_TFT      = 2'b01;
	localparam int unsigned PT_WIDE_BIT = 4;
	localparam int unsigned POL_BIT     = 7;
	// Timing offsets, in pixels or lines
	localparam logic [10:0] H_ONE     = 11'h001;
	localparam int unsigned H_SHIFT   = 3;
	localparam logic [10:0] HORIZ_ACTIVE_START_OFS  = 11'h005;
	localparam logic [10:0] BIAS_HCNT = 11'h001;
	localparam logic [10:0] SC16_PER  = 11'h005;
	localparam logic [10:0] SC16_HIGH = 11'h003;
	localparam logic [10:0] DE_MAX    = 11'h0fa;
	typedef enum logic [0:0] {
		BUS_IDLE = 1'b0,
		BUS_ACK  = 1'b1
	} lpt_bus_state_t;
	typedef struct packed {
		logic [7:0]  address;
		logic        read;
		logic        write;
		logic [31:0] writedata;
	} lpt_avs_req_t;
	typedef struct packed {
		logic        frame_pulse;
		logic        line_pulse;
		logic        shift_clock;
		logic        ac_bias_toggle;
		logic        display_enable_strobe;
		logic [15:0] panel_data_bus;
	} lpt_panel_t;
endpackage : lpt_pkg

// File: tb/lpt_panel_model.sv
// Purpose: Panel side model that measures link timing
// Assumes: Two clk per pixel; levels sampled on clk
// Notes:   m[0] to m[4] count clk, m[5] to m[7] count lines; lpol and fpol give the active levels
`timescale 1ns/1ns
`default_nettype none
module lpt_panel_model (
	input  wire logic                clk,
	input  wire lpt_pkg::lpt_panel_t panel,
	input  wire logic                lpol,
	input  wire logic                fpol,
	output var  int                  m [8]
);
	import lpt_pkg::*;
	int   lc = 0, wc = 0, dc = 0, dd = 0, sc = 0, ln = 0, fc = 0, dl = 0;
	logic la_q = 0, fa_q = 0, de_q = 0, sk_q = 0;
	wire logic la = panel.line_pulse === lpol;
	wire logic fa = panel.frame_pulse === fpol;
	wire logic de = panel.display_enable_strobe === 1'b1;
	wire logic sk = panel.shift_clock === 1'b1;
	initial m = '{default: 0};
	always @(posedge clk) begin
		{la_q, fa_q, de_q, sk_q} <= {la, fa, de, sk};
		lc <= lc + 1;
		dd <= dd + 1;
		sc <= sc + 1;
		if (la) wc <= wc + 1;
		if (de) dc <= dc + 1;
		if (la && !la_q) begin
			m[0] <= lc;
			lc <= 1;
			dd <= 1;
			ln <= ln + 1;
			if (fa) fc <= fc + 1;
		end
		if (!la && la_q) begin
			m[1] <= wc;
			wc <= 0;
		end
		if (de && !de_q) begin
			m[3] <= dd;
			dl <= dl + 1;
		end
		if (!de && de_q) begin
			m[2] <= dc;
			dc <= 0;
		end
		// Gaps between lines are ignored, only in-line periods kept
		if (sk && !sk_q) begin
			sc <= 1;
			if (sc < 24) m[4] <= sc;
		end
		if (fa && !fa_q) begin
			m[5] <= ln;
			ln <= 0;
			m[7] <= dl;
			dl <= 0;
		end
		if (!fa && fa_q) begin
			m[6] <= fc;
			fc <= 0;
		end
	end
endmodule : lpt_panel_model
`default_nettype wire

// File: tb/lpt_timing_gen_tb.sv
// Purpose: Self-checking bench of the panel timing generator
// Assumes: 20 MHz clk, one wait state on the register bus
// Notes:   Expectations in clk cycles, frame and display-line counts in lines, worked from field values
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, s) begin n_checks++; if ((e) !== (s)) begin bad_count++; \
	$display("MISMATCH %s exp %0d got %0d", n, e, s); end end
module lpt_timing_gen_tb;
	import lpt_pkg::*;
	logic         clk = 0, rst = 1, wq, take, lpol = 0, fpol = 0;
	lpt_avs_req_t req = '0;
	logic [31:0]  rd;
	logic [15:0]  pix = '0;
	lpt_panel_t   pnl;
	int           m [8];
	int           bad_count = 0, n_checks = 0, seed = 32'h7804be1c, h, i, p;
	logic [7:0]   q, d, v [17];
	logic [5:0]   ix [17] = '{6'h10, 6'h12, 6'h14, 6'h16, 6'h17, 6'h18, 6'h19, 6'h1c,
		6'h1d, 6'h1e, 6'h1f, 6'h20, 6'h22, 6'h23, 6'h24, 6'h26, 6'h27};
	initial forever #25 clk = ~clk;
	always @(posedge clk) pix <= $random(seed);
	lpt_timing_gen DUT (.clk(clk), .rst(rst), .avs_req(req), .avs_readdata(rd),
		.avs_waitrequest(wq), .pixel_in(pix), .pixel_take(take), .panel(pnl));
	lpt_panel_model pm (.clk(clk), .panel(pnl), .lpol(lpol), .fpol(fpol), .m(m));
	task end_sim;
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : end_sim
	task bus(input logic wr, input logic [5:0] a, input logic [7:0] dv);
		int k;
		req <= '{address: {a, 2'b00}, read: !wr, write: wr, writedata: {24'h0, dv}};
		for (k = 0; k < 20; k++) begin
			@(negedge clk);
			if (wq === 1'b0) break;
		end
		q = rd[7:0];
		@(posedge clk);
		req.read <= 1'b0;
		req.write <= 1'b0;
		@(posedge clk);
		if (k == 20) begin
			bad_count++;
			end_sim;
		end
	endtask : bus
	task cfg(input logic [7:0] pt, input logic pl);
		int j;
		// Display width field 1 gives 16 pixels, a multiple of eight
		v = '{pt, h[7:0], 8'h01, 8'h03, 8'h00, 8'h09, 8'h00, 8'h03, 8'h00, 8'h04, 8'h00,
			{pl, 7'h02}, 8'h01, 8'h00, {pl, 7'h01}, 8'h01, 8'h00};
		for (j = 0; j < 17; j++) bus(1'b1, ix[j], v[j]);
		lpol = pl;
		fpol = pl;
		repeat (500 * (h + 1)) @(posedge clk);
	endtask : cfg
	initial begin
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		for (i = 0; i < 17; i++) begin
			bus(1'b0, ix[i], 8'h00);
			`CHK("reset value", 8'h00, q)
		end
		bus(1'b1, 6'h3f, 8'h5a);
		bus(1'b0, 6'h3f, 8'h00);
		`CHK("unmapped", 8'h00, q)
		for (i = 0; i < 17; i++) begin
			d = $random(seed);
			if (i == 0) d[1:0] = 2'b00;
			bus(1'b1, ix[i], d);
			bus(1'b0, ix[i], 8'h00);
			`CHK("readback", d, q)
		end
		h = 3 + ($random(seed) & 3);
		for (p = 0; p < 2; p++) begin
			cfg(8'h01, p[0]);
			`CHK("line period", (h + 1) * 16, m[0])
			`CHK("line width", 6, m[1])
			`CHK("enable width", 32, m[2])
			`CHK("enable delay", ((3 + 5) - (1 + 1)) * 2, m[3])
			`CHK("tft shift", 2, m[4])
			`CHK("frame period", 10, m[5])
			`CHK("frame width", 2, m[6])
			`CHK("display lines", 4, m[7])
		end
		cfg(8'h00, 1'b0);
		`CHK("f2 shift", 4, m[4])
		`CHK("passive line", (h + 1) * 16, m[0])
		cfg(8'h10, 1'b0);
		`CHK("w16 shift", 10, m[4])
		`CHK("w16 line width", 6, m[1])
		end_sim;
	end
	initial begin
		#3000000;
		bad_count++;
		end_sim;
	end
endmodule : lpt_timing_gen_tb
`default_nettype wire
